// >>> dv/stp_pin_source.sv
// behavioural external clock source driving both count pins
`timescale 1ns/100ps
module stp_pin_source (
  // control from the bench
  input  wire logic       run,
  input  wire logic [3:0] half,
  // count pins, index 0 timer0, 1 timer1
  output logic [1:0]      pin
);
  // one variable per pin so each has a single driving process
  logic pin0_r = 1'b0;
  logic pin1_r = 1'b0;
  assign pin = {pin1_r, pin0_r};

  // half period of at least two cycles, phase unrelated to the system clock
  always begin
    if (run) begin
      #(half * 100 + 30);
      pin0_r = ~pin0_r;
    end else begin
      @(run);
    end
  end

  // second pin at a slower rate so the two timers see different traffic
  always begin
    if (run) begin
      #((half + 1) * 100 + 70);
      pin1_r = ~pin1_r;
    end else begin
      @(run);
    end
  end
endmodule : stp_pin_source

// >>> dv/stp_timer_clock_test.sv
// self-checking bench for the shared prescaler and clock select block
`timescale 1ns/100ps
module stp_timer_clock_test;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, wrap, rev, pc, gie, ack, irq, run, cnt_en;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, half;
  logic [1:0]  bresp, rresp, pin, synced, pulse;
  logic [7:0]  misc, rnd;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          fail_count, check_count, p0, p1, e0, e1;
  int          dv[6] = '{0, 1, 8, 64, 256, 1024};

  stp_timer_clock #(.ADDR_W(5)) stp_timer_clock_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_count_pin(pin), .synced_count_input(synced), .timer_clock_pulse(pulse),
    .timer0_wrap(wrap), .timer0_bottom_reverse(rev), .timer0_phase_correct(pc),
    .global_irq_enable(gie), .timer0_vector_ack(ack), .timer0_overflow_irq(irq),
    .misc_function_bits(misc));

  stp_pin_source stp_pin_source_inst (.run(run), .half(half), .pin(pin));

  // 10 mhz system clock
  initial aclk = 1'b0;
  always #50 aclk = ~aclk;

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // write with address and data offered together, each released once taken
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ha, hw, da, dw;
    exp_b.push_back(er);
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ha = awready && !da;
      hw = wready && !dw;
      @(posedge aclk);
      if (ha) begin
        awvalid <= 1'b0;
        da = 1'b1;
      end
      if (hw) begin
        wvalid <= 1'b0;
        dw = 1'b1;
      end
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_wr

  // read; the expected response and data are noted for the monitor
  task automatic axi_rd(input logic [4:0] a, input logic [33:0] er);
    exp_r.push_back(er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_rd

  // count timer clock pulses over n edges
  task automatic win(input int n);
    @(posedge aclk);
    p0 = 0;
    p1 = 0;
    cnt_en <= 1'b1;
    repeat (n) @(posedge aclk);
    cnt_en <= 1'b0;
    // let the monitor add the last edge before the counts are read
    @(negedge aclk);
  endtask : win

  // monitor: oldest note against each response, plus pulse counting
  always @(posedge aclk) begin
    if (rvalid && rready && exp_r.size() > 0) check({rresp, rdata}, exp_r.pop_front());
    if (bvalid && bready && exp_b.size() > 0) check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
    if (cnt_en) begin
      p0 += int'(pulse[0]);
      p1 += int'(pulse[1]);
    end
  end

  // raw pin edges, the reference for the edge detector
  always @(posedge pin[0]) if (cnt_en) e0++;
  always @(negedge pin[1]) if (cnt_en) e1++;

  // watchdog, well beyond the roughly 14k cycles the tests need
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    $display("Error at %0t: timeout", $time);
    test_done;
  end

  initial begin
    void'($urandom(32'h11560466));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, wrap, rev, pc, gie, ack, run, cnt_en} = '0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    half = 4'h2;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped place refused
    for (int a = 0; a < 5; a++) axi_rd(5'(a * 4), 34'h0);
    axi_rd(5'h18, {stp_pkg::RESP_SLVERR, 32'h0});
    axi_wr(5'h18, 32'h1, 4'hf, stp_pkg::RESP_SLVERR);
    // misc register: reset bit reads zero, reserved bit stays zero
    rnd = 8'($urandom);
    axi_wr(stp_pkg::ADDR_MISC, {24'h0, rnd}, 4'hf, stp_pkg::RESP_OKAY);
    axi_wr(stp_pkg::ADDR_MISC, 32'h0, 4'h0, stp_pkg::RESP_OKAY);
    axi_rd(stp_pkg::ADDR_MISC, {2'h0, 24'h0, rnd & stp_pkg::MISC_WMASK});
    check({26'h0, misc}, {26'h0, rnd & stp_pkg::MISC_WMASK});
    // every internal select on timer0 while timer1 stays on its own tap
    axi_wr(stp_pkg::ADDR_CS1, {29'h0, stp_pkg::CS_DIV64}, 4'hf, stp_pkg::RESP_OKAY);
    for (int c = 0; c < 6; c++) begin
      axi_wr(stp_pkg::ADDR_CS0, 32'(c), 4'hf, stp_pkg::RESP_OKAY);
      win(2048);
      check(34'(p0), (c == 0) ? 34'h0 : 34'(2048 / dv[c]));
      check(34'(p1), 34'd32);
    end
    // prescaler reset restarts the divide by 1024 period
    axi_wr(stp_pkg::ADDR_CS0, {29'h0, stp_pkg::CS_DIV1024}, 4'hf, stp_pkg::RESP_OKAY);
    axi_wr(stp_pkg::ADDR_MISC, 32'h1, 4'hf, stp_pkg::RESP_OKAY);
    win(1000);
    check(34'(p0), 34'h0);
    win(50);
    check(34'(p0), 34'h1);
    axi_rd(stp_pkg::ADDR_MISC, 34'h0);
    // external pins: selects change only while the pins are still
    axi_wr(stp_pkg::ADDR_CS0, {29'h0, stp_pkg::CS_EXT_RISE}, 4'hf, stp_pkg::RESP_OKAY);
    axi_wr(stp_pkg::ADDR_CS1, {29'h0, stp_pkg::CS_EXT_FALL}, 4'hf, stp_pkg::RESP_OKAY);
    @(posedge aclk);
    half <= 4'h2 + 4'($urandom % 4);
    p0 = 0;
    p1 = 0;
    cnt_en <= 1'b1;
    run <= 1'b1;
    repeat (400) @(posedge aclk);
    run <= 1'b0;
    repeat (30) @(posedge aclk);
    cnt_en <= 1'b0;
    @(negedge aclk);
    check(34'(p0), 34'(e0));
    check(34'(p1), 34'(e1));
    check({32'h0, synced}, {32'h0, pin});
    // flag source per mode: wrap outside phase correct, reversal inside
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      pc <= i[1];
      wrap <= !i[0];
      rev <= i[0];
      @(posedge aclk);
      wrap <= 1'b0;
      rev <= 1'b0;
      axi_rd(stp_pkg::ADDR_FLAGS, {33'h0, i[1] == i[0]});
      axi_wr(stp_pkg::ADDR_FLAGS, 32'h1, 4'hf, stp_pkg::RESP_OKAY);
      axi_rd(stp_pkg::ADDR_FLAGS, 34'h0);
    end
    // interrupt qualification with the flag set
    @(posedge aclk);
    pc <= 1'b0;
    wrap <= 1'b1;
    @(posedge aclk);
    wrap <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      axi_wr(stp_pkg::ADDR_MASK, 32'(m), 4'hf, stp_pkg::RESP_OKAY);
      for (int g = 0; g < 2; g++) begin
        @(posedge aclk);
        gie <= g[0];
        @(negedge aclk);
        check({33'h0, irq}, {33'h0, m[0] & g[0]});
      end
    end
    // vector execution clears the flag and drops the request
    @(posedge aclk);
    ack <= 1'b1;
    @(posedge aclk);
    ack <= 1'b0;
    @(negedge aclk);
    check({33'h0, irq}, 34'h0);
    axi_rd(stp_pkg::ADDR_FLAGS, 34'h0);
    test_done;
  end
endmodule : stp_timer_clock_test

// >>> src/stp_clock_select.sv
// per-timer clock source multiplexer
`timescale 1ns/100ps
module stp_clock_select (
  // selection
  input  logic [2:0] clock_select_field,
  // candidate sources
  input  logic [3:0] taps,
  input  logic       ext_rise,
  input  logic       ext_fall,
  // result
  output logic       timer_clock_pulse
);

  // each timer picks independently from the shared taps
  always_comb begin
    case (stp_pkg::stp_cs_t'(clock_select_field))
      stp_pkg::CS_STOP:     timer_clock_pulse = 1'b0;
      stp_pkg::CS_DIRECT:   timer_clock_pulse = 1'b1;
      stp_pkg::CS_DIV8:     timer_clock_pulse = taps[0];
      stp_pkg::CS_DIV64:    timer_clock_pulse = taps[1];
      stp_pkg::CS_DIV256:   timer_clock_pulse = taps[2];
      stp_pkg::CS_DIV1024:  timer_clock_pulse = taps[3];
      stp_pkg::CS_EXT_FALL: timer_clock_pulse = ext_fall;
      stp_pkg::CS_EXT_RISE: timer_clock_pulse = ext_rise;
      default:              timer_clock_pulse = 1'b0;
    endcase
  end

endmodule : stp_clock_select

// >>> src/stp_pin_edge.sv
// two-flop synchroniser and edge detector for one external count pin
`timescale 1ns/100ps
module stp_pin_edge (
  // clock and reset
  input  logic aclk,
  input  logic aresetn,
  // pin side
  input  logic external_count_pin,
  // detector outputs
  output logic synced_count_input,
  output logic rise,
  output logic fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // pin sampled once per clock; meta_r is read only by sync_r
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= external_count_pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // one pulse per edge, counted at the next edge: total delay 2 to 3 clocks
  assign synced_count_input = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule : stp_pin_edge

// >>> src/stp_pkg.sv
// shared constants for the timer prescaler and clock select block
package stp_pkg;

  // register byte offsets on the axi4-lite port
  localparam logic [4:0] ADDR_MISC  = 5'h00;  // misc_function_control
  localparam logic [4:0] ADDR_CS0   = 5'h04;  // timer0 clock_select_field
  localparam logic [4:0] ADDR_CS1   = 5'h08;  // timer1 clock_select_field
  localparam logic [4:0] ADDR_FLAGS = 5'h0c;  // timer0_overflow_flag, write one to clear
  localparam logic [4:0] ADDR_MASK  = 5'h10;  // timer0_overflow_irq_enable
  localparam logic [4:0] ADDR_PRESC = 5'h14;  // live prescaler count, read only

  // field positions
  localparam int PSR_BIT  = 0;  // shared_prescaler_reset in misc_function_control
  localparam int TOV_BIT  = 0;  // timer0_overflow_flag
  localparam int TOIE_BIT = 0;  // timer0_overflow_irq_enable
  localparam int CS_W     = 3;  // width of a clock_select_field

  // reset values and writable bits of misc_function_control
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [7:0] MISC_WMASK = 8'hee;  // bit 4 reserved, bit 0 self-clearing
  localparam logic [2:0] CS_RESET   = 3'h0;

  // clock select encodings
  typedef enum logic [2:0] {
    CS_STOP    = 3'h0,
    CS_DIRECT  = 3'h1,
    CS_DIV8    = 3'h2,
    CS_DIV64   = 3'h3,
    CS_DIV256  = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } stp_cs_t;

  // prescaler tap widths: divide by 8, 64, 256, 1024
  localparam int PRESC_W   = 10;
  localparam int TAP0_BITS = 3;
  localparam int TAP1_BITS = 6;
  localparam int TAP2_BITS = 8;
  localparam int TAP3_BITS = 10;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : stp_pkg

// >>> src/stp_timer_clock.sv
// shared prescaler, clock selection and timer0 overflow flag with axi4-lite registers
// Behaviour
// - outside phase correct mode, timer0 overflow flag is set whenever the 8-bit timer wraps.
// - flag clears by hardware when the overflow interrupt vector executes.
// - writing one to the flag clears it; a write never sets it.
// - overflow interrupt only while global enable, overflow enable and flag are one.
// - in phase correct mode the flag sets on direction reversal at zero.
// - both timers share one prescaler but keep separate clock selects.
// - clock select one clocks the timer at the full system clock.
// - prescaler offers taps at divide by 8, 64, 256 and 1024.
// - prescaler free-runs regardless of clock select; first count after 1..N+1 clocks.
// - count pin sampled every rising clock edge through a synchroniser.
// - select 7 counts rising pin edges, select 6 counts falling ones.
// - counter update follows a pin edge by 2 to 3 clocks.
// - external pin clock bypasses the prescaler, undivided.
// - writing one to the prescaler reset bit resets the shared prescaler.
// - prescaler reset bit self-clears, ignores zero writes, reads as zero.
// - clock select zero gives no clock; counter stays stopped.
// - selects 2 to 5 pick taps in ascending division order.
`timescale 1ns/100ps
module stp_timer_clock #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input  logic              aclk,
  input  logic              aresetn,
  // axi4-lite write address
  input  logic [ADDR_W-1:0] s_axi_awaddr,
  input  logic              s_axi_awvalid,
  output logic              s_axi_awready,
  // axi4-lite write data
  input  logic [31:0]       s_axi_wdata,
  input  logic [3:0]        s_axi_wstrb,
  input  logic              s_axi_wvalid,
  output logic              s_axi_wready,
  // axi4-lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  logic              s_axi_bready,
  // axi4-lite read address
  input  logic [ADDR_W-1:0] s_axi_araddr,
  input  logic              s_axi_arvalid,
  output logic              s_axi_arready,
  // axi4-lite read data
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  logic              s_axi_rready,
  // external count pins, index 0 for timer0, 1 for timer1
  input  logic [1:0]        external_count_pin,
  output logic [1:0]        synced_count_input,
  // timer clock enables to the two counters
  output logic [1:0]        timer_clock_pulse,
  // timer0 core events and processor side
  input  logic              timer0_wrap,
  input  logic              timer0_bottom_reverse,
  input  logic              timer0_phase_correct,
  input  logic              global_irq_enable,
  input  logic              timer0_vector_ack,
  output logic              timer0_overflow_irq,
  // remaining misc_function_control bits for other blocks
  output logic [7:0]        misc_function_bits
);

  // parameter check
  if (ADDR_W < 5) begin : g_bad_addr
    $error("stp_timer_clock: ADDR_W must be at least 5");
  end

  // bus state
  logic              aw_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic              w_held_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  // register state
  logic [7:0]        misc_r;
  logic [2:0]        cs0_r;
  logic [2:0]        cs1_r;
  logic              flag_r;
  logic              flag_nxt;
  logic              mask_r;
  logic              presc_clr_r;
  logic [stp_pkg::PRESC_W-1:0] presc_r;

  // handshake outputs: one write and one read in flight at most
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // write decode, low byte lane only since every writable register is 8 bits or less
  wire wr_go    = aw_held_r & w_held_r & ~bvalid_r;
  wire wr_lane  = wr_go & wstrb_r[0];
  wire wa_misc  = awaddr_r == ADDR_W'(stp_pkg::ADDR_MISC);
  wire wa_cs0   = awaddr_r == ADDR_W'(stp_pkg::ADDR_CS0);
  wire wa_cs1   = awaddr_r == ADDR_W'(stp_pkg::ADDR_CS1);
  wire wa_flags = awaddr_r == ADDR_W'(stp_pkg::ADDR_FLAGS);
  wire wa_mask  = awaddr_r == ADDR_W'(stp_pkg::ADDR_MASK);
  wire wa_presc = awaddr_r == ADDR_W'(stp_pkg::ADDR_PRESC);
  wire wa_hit   = wa_misc | wa_cs0 | wa_cs1 | wa_flags | wa_mask | wa_presc;
  wire psr_req  = wr_lane & wa_misc & wdata_r[stp_pkg::PSR_BIT];
  wire tov_w1c  = wr_lane & wa_flags & wdata_r[stp_pkg::TOV_BIT];

  // read decode; the prescaler reset bit is never stored so it reads zero
  wire ra_misc  = s_axi_araddr == ADDR_W'(stp_pkg::ADDR_MISC);
  wire ra_cs0   = s_axi_araddr == ADDR_W'(stp_pkg::ADDR_CS0);
  wire ra_cs1   = s_axi_araddr == ADDR_W'(stp_pkg::ADDR_CS1);
  wire ra_flags = s_axi_araddr == ADDR_W'(stp_pkg::ADDR_FLAGS);
  wire ra_mask  = s_axi_araddr == ADDR_W'(stp_pkg::ADDR_MASK);
  wire ra_presc = s_axi_araddr == ADDR_W'(stp_pkg::ADDR_PRESC);
  wire ra_hit   = ra_misc | ra_cs0 | ra_cs1 | ra_flags | ra_mask | ra_presc;
  wire [31:0] rd_mux =
      ra_misc  ? {24'h000000, misc_r} :
      ra_cs0   ? {29'h0, cs0_r} :
      ra_cs1   ? {29'h0, cs1_r} :
      ra_flags ? {31'h0, flag_r} :
      ra_mask  ? {31'h0, mask_r} :
      ra_presc ? {22'h0, presc_r} : 32'h00000000;

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
      w_held_r  <= 1'b0;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= stp_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wa_hit ? stp_pkg::RESP_OKAY : stp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read channel: data registered the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= stp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= ra_hit ? stp_pkg::RESP_OKAY : stp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // control registers; bit 0 of misc is a strobe, not storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      misc_r <= stp_pkg::MISC_RESET;
      cs0_r  <= stp_pkg::CS_RESET;
      cs1_r  <= stp_pkg::CS_RESET;
      mask_r <= 1'b0;
    end else if (wr_lane) begin
      if (wa_misc) misc_r <= (misc_r & ~stp_pkg::MISC_WMASK) | (wdata_r[7:0] & stp_pkg::MISC_WMASK);
      if (wa_cs0)  cs0_r  <= wdata_r[2:0];
      if (wa_cs1)  cs1_r  <= wdata_r[2:0];
      if (wa_mask) mask_r <= wdata_r[stp_pkg::TOIE_BIT];
    end
  end
  assign misc_function_bits = misc_r;

  // overflow flag: phase correct mode sets at the bottom reversal, set beats any clear
  wire tov_set = timer0_phase_correct ? timer0_bottom_reverse : timer0_wrap;
  always_comb begin
    if (tov_set)
      flag_nxt = 1'b1;
    else if (timer0_vector_ack || tov_w1c)
      flag_nxt = 1'b0;
    else
      flag_nxt = flag_r;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) flag_r <= 1'b0;
    else          flag_r <= flag_nxt;
  end
  assign timer0_overflow_irq = global_irq_enable & mask_r & flag_r;

  // shared prescaler: free running, cleared the cycle after a reset request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_clr_r <= 1'b0;
      presc_r     <= '0;
    end else begin
      presc_clr_r <= psr_req;
      if (presc_clr_r) presc_r <= '0;
      else             presc_r <= presc_r + 1'b1;
    end
  end

  // one-cycle tap enables; the clear re-aligns all taps together
  logic [3:0] taps;
  assign taps[0] = &presc_r[stp_pkg::TAP0_BITS-1:0];
  assign taps[1] = &presc_r[stp_pkg::TAP1_BITS-1:0];
  assign taps[2] = &presc_r[stp_pkg::TAP2_BITS-1:0];
  assign taps[3] = &presc_r[stp_pkg::TAP3_BITS-1:0];

  // per timer: pin synchroniser and clock source select, taps shared
  logic [1:0] ext_rise;
  logic [1:0] ext_fall;
  wire  [2:0] cs_sel [2] = '{cs0_r, cs1_r};
  for (genvar t = 0; t < 2; t++) begin : g_timer
    stp_pin_edge stp_pin_edge_inst (
      .aclk               (aclk),
      .aresetn            (aresetn),
      .external_count_pin (external_count_pin[t]),
      .synced_count_input (synced_count_input[t]),
      .rise               (ext_rise[t]),
      .fall               (ext_fall[t])
    );
    stp_clock_select stp_clock_select_inst (
      .clock_select_field (cs_sel[t]),
      .taps               (taps),
      .ext_rise           (ext_rise[t]),
      .ext_fall           (ext_fall[t]),
      .timer_clock_pulse  (timer_clock_pulse[t])
    );
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ovf_sets_flag: assert property (timer0_wrap && !timer0_phase_correct |=> flag_r)
    else $error("overflow did not set flag");
  a_vector_clears: assert property (timer0_vector_ack && !tov_set |=> !flag_r)
    else $error("vector ack did not clear flag");
  a_w1c_clears: assert property (tov_w1c && !tov_set |=> !flag_r)
    else $error("write one did not clear flag");
  a_write_no_set: assert property (!flag_r && !tov_set && wr_lane && wa_flags |=> !flag_r)
    else $error("write set the flag");
  a_irq_gating: assert property (timer0_overflow_irq |-> global_irq_enable && mask_r && flag_r)
    else $error("irq without all three enables");
  a_pc_no_wrap: assert property (timer0_phase_correct && timer0_wrap && !timer0_bottom_reverse
                                 && !flag_r |=> !flag_r)
    else $error("wrap set flag in phase correct mode");
  a_direct_clock: assert property (cs0_r == 3'h1 |-> timer_clock_pulse[0])
    else $error("direct select gave no pulse");
  // a prescaler reset may land mid-period, so any attempt it overlaps is dropped
  a_tap8_period: assert property (disable iff (!aresetn || presc_clr_r)
                                  taps[0] |=> !taps[0] [*7] ##1 taps[0])
    else $error("divide by 8 tap period wrong");
  a_presc_free_run: assert property (!presc_clr_r |=> presc_r == $past(presc_r) + 1'b1)
    else $error("prescaler did not advance");
  a_presc_restart: assert property (psr_req |=> presc_clr_r ##1 presc_r == '0)
    else $error("prescaler not cleared after reset write");
  a_psr_reads_zero: assert property (s_axi_rvalid |-> !rdata_r[stp_pkg::PSR_BIT] || !$past(ra_misc))
    else $error("prescaler reset bit read as one");
  a_ext_rise_delay: assert property ($rose(synced_count_input[0]) && cs0_r == 3'h7 |-> timer_clock_pulse[0])
    else $error("rising pin edge gave no pulse");
  a_stop_no_clock: assert property (cs1_r == 3'h0 |-> !timer_clock_pulse[1])
    else $error("stopped timer got a pulse");
  a_ext_fall_pulse: assert property ($fell(synced_count_input[1]) && cs1_r == 3'h6 |-> timer_clock_pulse[1])
    else $error("falling pin edge gave no pulse");

  c_psr_write:  cover property (psr_req);
  c_ext_fall:   cover property (cs1_r == 3'h6 && timer_clock_pulse[1]);
  c_irq_raised: cover property ($rose(timer0_overflow_irq));
  c_set_vs_clr: cover property (tov_set && tov_w1c);

endmodule : stp_timer_clock
